// ---- nvmcc_pkg.sv ----
/*
 Package for the nonvolatile memory configuration block: register offsets,
 field positions, reset values and decode constants.
 Assumes a byte-wide register port and a single bus clock.
*/
package nvmcc_pkg;
   // Register offsets on the plain register port
   localparam logic [2:0] NVMCC_OFS_RATIO = 3'h0;
   localparam logic [2:0] NVMCC_OFS_CONFIG = 3'h1;
   localparam logic [2:0] NVMCC_OFS_OPTIONS = 3'h2;
   localparam logic [2:0] NVMCC_OFS_ECCCTL = 3'h3;
   localparam logic [2:0] NVMCC_OFS_STATUS = 3'h4;
   // Field positions
   localparam int NVMCC_LOADED_BIT = 7;
   localparam int NVMCC_PRESCALE_BIT = 6;
   localparam int NVMCC_RATIO_W = 6;
   localparam int NVMCC_PAGE_BIT = 6;
   localparam int NVMCC_LAYOUT_BIT = 5;
   // Reset values
   localparam logic [7:0] NVMCC_RATIO_RST = 8'h00;
   localparam logic NVMCC_PAGE_RST = 1'b0;
   localparam logic NVMCC_ECC_OFF_RST = 1'b1;
   // ECC configuration byte decode
   localparam logic [7:0] NVMCC_CFG_ERASED = 8'hFF;
   localparam logic [3:0] NVMCC_CFG_NIBBLE_ON = 4'h6;
   // Prescaler divides the bus clock by this count
   localparam int NVMCC_PRESCALE_DIV = 8;
   localparam logic [2:0] NVMCC_PRESCALE_LAST = 3'(NVMCC_PRESCALE_DIV - 1);
   // Bus clock and memory clock window
   localparam int NVMCC_BUS_HZ = 10000000;
   localparam int NVMCC_FCLK_MAX_HZ = 200000;
   localparam int NVMCC_FCLK_MIN_HZ = 150000;
   // EEPROM and flash sector geometry
   localparam int NVMCC_EE_SECTOR_BYTES = 8;
   localparam int NVMCC_EE_HALF_BYTES = 4;
   localparam int NVMCC_FLASH_SECTOR_ECC = 512;
   // Reset sequence length in bus cycles for the configuration fetch
   localparam logic [1:0] NVMCC_FETCH_CYCLES = 2'h2;
   typedef enum logic [1:0] {NVMCC_S_FETCH, NVMCC_S_DECIDE, NVMCC_S_RUN} nvmcc_state_t;
endpackage

// ---- nvmcc_top.sv ----
/*
 Configuration logic of the flash/EEPROM system: reset-time ECC enable
 decode, ECC parity encode/correct, EEPROM page mapping and the write-once
 program/erase clock divider.
 Assumes synchronous inputs, the configuration byte presented raw (parity
 ignored) on NVM_CFG_DATA during the reset sequence, and a plain register port.
*/
// Operation
// - Erased config byte leaves ECC disabled
// - Either nibble six at reset enables ECC
// - Decide from data bits, parity ignored
// - Parity of 0x66 equals 0xF
// - Debug controller may write ECC-off bit
// - Four parity bits per byte, correct singles
// - ECC on: 512-byte sectors, continuous remap
// - Only foreground EEPROM half is visible
// - Split mode: halves share addresses per page
// - Split mode erase clears all eight bytes
// - Whole mode: sector in one page only
// - Loaded flag read-only, set by first write
// - Ratio bits accept only first write
// - Program/erase blocked until ratio loaded
// - Prescale bit selects bus or bus/8
// - Memory clock is input over ratio+1
// - Timing pulse lasts one bus cycle per memory clock
// - Page select picks page shown in map
// - Hamming correction on every read with ECC
`timescale 1ns/1ps
module nvmcc_top
   import nvmcc_pkg::*;
#(
   parameter int EE_ADDR_W = 10
)
(
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // Register port
   input wire logic [2:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic REG_BDM,
   output logic [7:0] REG_RDATA,
   // Configuration byte fetched during reset sequence
   input wire logic [7:0] NVM_CFG_DATA,
   output logic CFG_FETCH_BUSY,
   // ECC datapath
   input wire logic [7:0] ECC_WR_DATA,
   output logic [3:0] ECC_WR_PARITY,
   input wire logic [7:0] ECC_RD_DATA,
   input wire logic [3:0] ECC_RD_PARITY,
   output logic [7:0] ECC_RD_FIXED,
   output logic ECC_RD_CORRECTED,
   output logic ECC_OFF,
   output logic FLASH_SECTOR_512,
   // EEPROM mapping
   input wire logic [EE_ADDR_W-1:0] EE_CPU_ADDR,
   input wire logic EE_ERASE_REQ,
   output logic [EE_ADDR_W:0] EE_ARRAY_ADDR,
   output logic [1:0] EE_ERASE_PAGES,
   // Program/erase control
   input wire logic PE_REQ,
   output logic PE_ALLOWED,
   output logic PE_TICK
);

   nvmcc_state_t state_q;
   logic [1:0] fetch_cnt_q;
   logic ecc_off_q;
   logic [7:0] ratio_q;
   logic page_q;
   logic layout_q;
   logic [2:0] pre_cnt_q;
   logic [NVMCC_RATIO_W-1:0] div_cnt_q;
   logic tick_q;
   logic [7:0] rdata_q;
   logic nib_hit;
   logic pre_tick;
   logic div_in;
   logic loaded;

   // Parity generator for a byte, Hamming (12,8) positions
   function automatic logic [3:0] nvmcc_parity(input logic [7:0] d);
      logic [3:0] p;
      // Columns per data bit 0..7: 5,3,9,6,7,A,C,B (all distinct, none a single bit)
      p[0] = d[0] ^ d[1] ^ d[2] ^ d[4] ^ d[7];
      p[1] = d[1] ^ d[3] ^ d[4] ^ d[5] ^ d[7];
      p[2] = d[0] ^ d[3] ^ d[4] ^ d[6];
      p[3] = d[2] ^ d[5] ^ d[6] ^ d[7];
      // Offset makes erased 0xFF give parity 0x0 and 0x66 give 0xF
      return p ^ 4'h3;
   endfunction

   // Offset cancels in the syndrome, so correction is unaffected by it
   assign ECC_WR_PARITY = nvmcc_parity(ECC_WR_DATA);

   // Syndrome decode corrects one flipped data bit while ECC is on
   logic [3:0] syn;
   logic [7:0] flip;
   assign syn = nvmcc_parity(ECC_RD_DATA) ^ ECC_RD_PARITY;
   always_comb
   begin
      flip = 8'h00;
      unique case (syn)
         4'h5: flip = 8'h01;
         4'h3: flip = 8'h02;
         4'h9: flip = 8'h04;
         4'h6: flip = 8'h08;
         4'h7: flip = 8'h10;
         4'hA: flip = 8'h20;
         4'hC: flip = 8'h40;
         4'hB: flip = 8'h80;
         default: flip = 8'h00;
      endcase
   end
   assign ECC_RD_FIXED = ecc_off_q ? ECC_RD_DATA : (ECC_RD_DATA ^ flip);
   assign ECC_RD_CORRECTED = !ecc_off_q && (flip != 8'h00);
   assign FLASH_SECTOR_512 = !ecc_off_q;
   assign ECC_OFF = ecc_off_q;

   // Either nibble matching covers a single flipped bit in the other
   assign nib_hit = (NVM_CFG_DATA[3:0] == NVMCC_CFG_NIBBLE_ON) ||
                    (NVM_CFG_DATA[7:4] == NVMCC_CFG_NIBBLE_ON);

   // Reset sequence: fetch the configuration byte, then decide
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         state_q <= NVMCC_S_FETCH;
         fetch_cnt_q <= 2'h0;
      end
      else
      begin
         unique case (state_q)
            NVMCC_S_FETCH:
            begin
               fetch_cnt_q <= fetch_cnt_q + 2'h1;
               if (fetch_cnt_q == NVMCC_FETCH_CYCLES - 2'h1)
                  state_q <= NVMCC_S_DECIDE;
            end
            NVMCC_S_DECIDE: state_q <= NVMCC_S_RUN;
            NVMCC_S_RUN: state_q <= NVMCC_S_RUN;
         endcase
      end
   end
   assign CFG_FETCH_BUSY = (state_q != NVMCC_S_RUN);

   // ECC-off bit: decided once per reset, debug controller may override
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         ecc_off_q <= NVMCC_ECC_OFF_RST;
      else if (state_q == NVMCC_S_DECIDE)
         ecc_off_q <= !nib_hit;
      else if (REG_WR && REG_BDM && REG_ADDR == NVMCC_OFS_ECCCTL)
         ecc_off_q <= REG_WDATA[0];
   end

   // Write-once clock ratio register
   assign loaded = ratio_q[NVMCC_LOADED_BIT];
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         ratio_q <= NVMCC_RATIO_RST;
      else if (REG_WR && REG_ADDR == NVMCC_OFS_RATIO && !loaded)
         ratio_q <= {1'b1, REG_WDATA[6:0]};
   end

   // EEPROM page select and sector layout
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         page_q <= NVMCC_PAGE_RST;
         layout_q <= 1'b0;
      end
      else if (REG_WR && REG_ADDR == NVMCC_OFS_CONFIG)
         page_q <= REG_WDATA[NVMCC_PAGE_BIT];
      else if (REG_WR && REG_ADDR == NVMCC_OFS_OPTIONS)
         layout_q <= REG_WDATA[NVMCC_LAYOUT_BIT];
   end

   // Prescaler gives one enable every eight bus cycles
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         pre_cnt_q <= 3'h0;
      else
         pre_cnt_q <= pre_tick ? 3'h0 : pre_cnt_q + 3'h1;
   end
   assign pre_tick = (pre_cnt_q == NVMCC_PRESCALE_LAST);
   assign div_in = ratio_q[NVMCC_PRESCALE_BIT] ? pre_tick : 1'b1;

   // Ratio divider; runs only once loaded so a late write cannot glitch it
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         div_cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= 1'b0;
         if (loaded && div_in)
         begin
            if (div_cnt_q == ratio_q[NVMCC_RATIO_W-1:0])
            begin
               div_cnt_q <= '0;
               tick_q <= 1'b1;
            end
            else
               div_cnt_q <= div_cnt_q + {{(NVMCC_RATIO_W-1){1'b0}}, 1'b1};
         end
      end
   end
   // Memory clock must sit in 150-200 kHz; that is software's choice of ratio
   assign PE_TICK = tick_q;
   assign PE_ALLOWED = loaded && PE_REQ;

   // EEPROM mapping: page bit is the extra array address bit
   always_comb
   begin
      EE_ARRAY_ADDR = {page_q, EE_CPU_ADDR};
      if (layout_q)
         EE_ERASE_PAGES = EE_ERASE_REQ ? (page_q ? 2'b10 : 2'b01) : 2'b00;
      else
         EE_ERASE_PAGES = EE_ERASE_REQ ? 2'b11 : 2'b00;
   end

   // Read data appear one cycle after the strobe
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         rdata_q <= 8'h00;
      else if (REG_RD)
      begin
         unique case (REG_ADDR)
            NVMCC_OFS_RATIO: rdata_q <= ratio_q;
            NVMCC_OFS_CONFIG: rdata_q <= {1'b0, page_q, 6'h00};
            NVMCC_OFS_OPTIONS: rdata_q <= {2'b00, layout_q, 5'h00};
            NVMCC_OFS_ECCCTL: rdata_q <= {7'h00, ecc_off_q};
            NVMCC_OFS_STATUS: rdata_q <= {6'h00, CFG_FETCH_BUSY, loaded};
            default: rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end
   assign REG_RDATA = rdata_q;

   a_parity_cfg_pattern: assert property (@(posedge SYS_CLK) disable iff (RST)
      (ECC_WR_DATA == 8'h66) |-> (ECC_WR_PARITY == 4'hF))
      else $error("parity of config pattern wrong");
   a_ecc_off_erased: assert property (@(posedge SYS_CLK) disable iff (RST)
      (state_q == NVMCC_S_DECIDE && NVM_CFG_DATA == NVMCC_CFG_ERASED) |=> ecc_off_q)
      else $error("erased config enabled ECC");
   a_ecc_on_nibble: assert property (@(posedge SYS_CLK) disable iff (RST)
      (state_q == NVMCC_S_DECIDE && nib_hit) |=> !ecc_off_q)
      else $error("nibble six did not enable ECC");
   a_ecc_off_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
      (state_q == NVMCC_S_RUN && !(REG_WR && REG_BDM && REG_ADDR == NVMCC_OFS_ECCCTL))
      |=> $stable(ecc_off_q))
      else $error("ECC-off bit changed without cause");
   a_ratio_once: assert property (@(posedge SYS_CLK) disable iff (RST)
      loaded |=> $stable(ratio_q))
      else $error("ratio changed after load");
   a_loaded_set: assert property (@(posedge SYS_CLK) disable iff (RST)
      (REG_WR && REG_ADDR == NVMCC_OFS_RATIO) |=> loaded)
      else $error("loaded flag not set by write");
   a_pe_blocked: assert property (@(posedge SYS_CLK) disable iff (RST)
      !loaded |-> !PE_ALLOWED && !PE_TICK)
      else $error("program allowed before ratio load");
   a_tick_spacing: assert property (@(posedge SYS_CLK) disable iff (RST)
      (PE_TICK && !ratio_q[NVMCC_PRESCALE_BIT] && ratio_q[5:0] == 6'h01) |-> ##2 PE_TICK)
      else $error("memory clock ratio wrong");
   a_erase_split: assert property (@(posedge SYS_CLK) disable iff (RST)
      (EE_ERASE_REQ && !layout_q) |-> EE_ERASE_PAGES == 2'b11)
      else $error("split erase missed a half");

   // Decode relies on the upper nibble alone when the lower one is damaged
   a_cfg_high_nibble: assert property (@(posedge SYS_CLK) disable iff (RST)
      (state_q == NVMCC_S_DECIDE && NVM_CFG_DATA[7:4] == NVMCC_CFG_NIBBLE_ON)
      |=> !ecc_off_q)
      else $error("upper nibble six ignored");

   // With ECC off the read path must pass data untouched
   a_ecc_bypass: assert property (@(posedge SYS_CLK) disable iff (RST)
      ecc_off_q |-> (ECC_RD_FIXED == ECC_RD_DATA) && !ECC_RD_CORRECTED)
      else $error("read data altered with ECC off");

   // A flip of data bit 4 is put back while ECC is on
   a_single_fix: assert property (@(posedge SYS_CLK) disable iff (RST)
      (!ecc_off_q && ECC_RD_PARITY == nvmcc_parity(ECC_RD_DATA ^ 8'h10))
      |-> (ECC_RD_FIXED == (ECC_RD_DATA ^ 8'h10)) && ECC_RD_CORRECTED)
      else $error("single-bit fault not corrected");

   // First ratio write lands as written
   a_ratio_first: assert property (@(posedge SYS_CLK) disable iff (RST)
      (REG_WR && REG_ADDR == NVMCC_OFS_RATIO && !loaded)
      |=> ratio_q[6:0] == $past(REG_WDATA[6:0]))
      else $error("first ratio write lost");

   // Late writes must not touch the running divider settings
   a_ratio_ignore: assert property (@(posedge SYS_CLK) disable iff (RST)
      (REG_WR && REG_ADDR == NVMCC_OFS_RATIO && loaded)
      |=> $stable(ratio_q) && $stable(div_cnt_q) || $past(div_in))
      else $error("late ratio write disturbed divider");

   // Loaded flag is what software reads in bit 7
   a_loaded_read: assert property (@(posedge SYS_CLK) disable iff (RST)
      (REG_RD && REG_ADDR == NVMCC_OFS_RATIO) |=> REG_RDATA[7] == $past(loaded))
      else $error("loaded flag read wrong");

   // Program/erase permitted once loaded
   a_pe_allowed: assert property (@(posedge SYS_CLK) disable iff (RST)
      (loaded && PE_REQ) |-> PE_ALLOWED)
      else $error("program refused after ratio load");

   // Prescaled divider advances only on the divide-by-eight enable
   a_prescale_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
      (ratio_q[NVMCC_PRESCALE_BIT] && !pre_tick) |=> $stable(div_cnt_q))
      else $error("divider ran between prescale enables");

   // A timing pulse is one bus cycle wide unless the period is one cycle
   a_tick_width: assert property (@(posedge SYS_CLK) disable iff (RST)
      (PE_TICK && (ratio_q[NVMCC_PRESCALE_BIT] || ratio_q[5:0] != 6'h00)) |=> !PE_TICK)
      else $error("timing pulse too long");

   // Page bit forms the top array address bit, low bits pass through
   a_page_map: assert property (@(posedge SYS_CLK) disable iff (RST)
      (EE_ARRAY_ADDR[EE_ADDR_W] == page_q) && (EE_ARRAY_ADDR[EE_ADDR_W-1:0] == EE_CPU_ADDR))
      else $error("EEPROM page mapping wrong");

   // Whole-sector erase touches only the foreground page
   a_erase_whole: assert property (@(posedge SYS_CLK) disable iff (RST)
      (EE_ERASE_REQ && layout_q) |-> EE_ERASE_PAGES == (page_q ? 2'b10 : 2'b01))
      else $error("whole erase hit background page");

   // No erase request, no page erased
   a_erase_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
      !EE_ERASE_REQ |-> EE_ERASE_PAGES == 2'b00)
      else $error("erase without request");

   // Sector size follows the ECC state
   a_sector_size: assert property (@(posedge SYS_CLK) disable iff (RST)
      FLASH_SECTOR_512 == !ECC_OFF)
      else $error("sector size does not follow ECC");

endmodule

// ---- nvmcc_cpu_model.sv ----
/*
 Partner model: the CPU or debug controller on the register port, plus the
 config byte source seen during the reset sequence.
 Assumes the plain register port of nvmcc_top and one bus clock.
*/
`timescale 1ns/1ps
module nvmcc_cpu_model
(
   // Clock
   input wire logic clk,
   // Register port, master side
   output logic [2:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   output logic bdm,
   input wire logic [7:0] rdata,
   // Raw config byte
   output logic [7:0] cfg
);
   // Idle bus, erased config byte
   initial
   begin
      addr = 3'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      bdm = 1'b0;
      cfg = 8'hFF;
   end
   // Config byte only matters while the fetch runs
   task automatic set_cfg(input logic [7:0] c);
      cfg <= c;
   endtask
   // One-cycle write; data inverted afterwards so stale values never match
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d, input logic dbg);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      bdm <= dbg;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      bdm <= 1'b0;
      wdata <= ~d;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule

// ---- nvmcc_top_tb.sv ----
/*
 Testbench for nvmcc_top: ECC decode at reset, ECC datapath, EEPROM map and
 the write-once divider. Assumes nvmcc_cpu_model drives the register port.
*/
`timescale 1ns/1ps
module nvmcc_top_tb
   import nvmcc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] ecc_wd = 8'h00;
   logic [7:0] ecc_rd = 8'h00;
   logic [3:0] ecc_rp = 4'h0;
   logic [9:0] ee_adr = 10'h000;
   logic ee_er = 1'b0;
   logic pe_req = 1'b0;
   logic [2:0] ra;
   logic [7:0] rw, rr, cfg, rdv, ecc_fix;
   logic wr, rd, bdm, busy, ecc_cor, ecc_off, sec512, pe_ok, pe_tick;
   logic [3:0] ecc_wp;
   logic [10:0] ee_arr;
   logic [1:0] ee_pages;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   nvmcc_cpu_model i_nvmcc_cpu_model (.clk(sys_clk), .addr(ra), .wdata(rw), .wr(wr), .rd(rd), .bdm(bdm),
      .rdata(rr), .cfg(cfg));
   nvmcc_top i_nvmcc_top (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(ra), .REG_WDATA(rw), .REG_WR(wr),
      .REG_RD(rd), .REG_BDM(bdm), .REG_RDATA(rr), .NVM_CFG_DATA(cfg), .CFG_FETCH_BUSY(busy),
      .ECC_WR_DATA(ecc_wd), .ECC_WR_PARITY(ecc_wp), .ECC_RD_DATA(ecc_rd), .ECC_RD_PARITY(ecc_rp),
      .ECC_RD_FIXED(ecc_fix), .ECC_RD_CORRECTED(ecc_cor), .ECC_OFF(ecc_off), .FLASH_SECTOR_512(sec512),
      .EE_CPU_ADDR(ee_adr), .EE_ERASE_REQ(ee_er), .EE_ARRAY_ADDR(ee_arr), .EE_ERASE_PAGES(ee_pages),
      .PE_REQ(pe_req), .PE_ALLOWED(pe_ok), .PE_TICK(pe_tick));
   // Bus clock, 100 ns period
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   // Hang guard; the whole run needs well under 2000 cycles
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("mismatches %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string w, input logic [10:0] seen, input logic [10:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic rchk(input string w, input logic [2:0] a, input logic [7:0] e);
      i_nvmcc_cpu_model.rd_reg(a, rdv);
      check(w, rdv, e);
   endtask
   // Reset for 10 cycles, then a bounded wait for the config fetch
   task automatic do_reset(input logic [7:0] c);
      int k;
      @(posedge sys_clk);
      rst <= 1'b1;
      i_nvmcc_cpu_model.set_cfg(c);
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      for (k = 0; k < 10 && busy !== 1'b0; k++) @(negedge sys_clk);
   endtask
   // Cycles between two timing pulses, sampled away from the edge
   task automatic tick_gap(output int gap);
      int k;
      for (k = 0; k < 900 && pe_tick !== 1'b1; k++) @(negedge sys_clk);
      @(negedge sys_clk);
      for (gap = 1; gap < 900 && pe_tick !== 1'b1; gap++) @(negedge sys_clk);
   endtask
   // Every decode case, with single-bit flips of both programmed values
   task automatic s_decode();
      logic [7:0] pat [7] = '{8'hFF, 8'h66, 8'h6F, 8'hF6, 8'hF7, 8'h67, 8'h00};
      logic offv [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      foreach (pat[i])
      begin
         do_reset(pat[i]);
         repeat (5) @(negedge sys_clk);
         check("ecc_off", ecc_off, offv[i]);
         check("sector512", sec512, !offv[i]);
      end
   endtask
   task automatic s_ecc();
      do_reset(8'h66);
      @(posedge sys_clk);
      ecc_wd <= 8'h66;
      ecc_rd <= 8'h76;
      ecc_rp <= 4'hF;
      @(negedge sys_clk);
      check("parity 66", ecc_wp, 4'hF);
      check("fixed", ecc_fix, 8'h66);
      check("corrected", ecc_cor, 1'b1);
      @(posedge sys_clk);
      ecc_wd <= 8'hFF;
      ecc_rd <= 8'h66;
      @(negedge sys_clk);
      check("parity FF", ecc_wp, 4'h0);
      check("clean", ecc_cor, 1'b0);
   endtask
   // Only the debug controller may clear the ECC-off bit
   task automatic s_bdm();
      do_reset(8'hFF);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_ECCCTL, 8'h00, 1'b0);
      @(negedge sys_clk);
      check("ecc_off user", ecc_off, 1'b1);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_ECCCTL, 8'h00, 1'b1);
      @(negedge sys_clk);
      check("ecc_off debug", ecc_off, 1'b0);
      rchk("ecc ctl rd", NVMCC_OFS_ECCCTL, 8'h00);
      rchk("unmapped", 3'h5, 8'h00);
   endtask
   // Ratio 49 gives 200 kHz from 10 MHz
   task automatic s_div();
      int gap;
      do_reset(8'hFF);
      @(posedge sys_clk);
      pe_req <= 1'b1;
      rchk("status", NVMCC_OFS_STATUS, 8'h00);
      check("pe blocked", pe_ok, 1'b0);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_RATIO, 8'h31, 1'b0);
      rchk("ratio", NVMCC_OFS_RATIO, 8'hB1);
      check("pe allowed", pe_ok, 1'b1);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_RATIO, 8'h40, 1'b0);
      rchk("ratio kept", NVMCC_OFS_RATIO, 8'hB1);
      tick_gap(gap);
      check("tick gap", gap, 11'h032);
      do_reset(8'hFF);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_RATIO, 8'h41, 1'b0);
      rchk("ratio pre8", NVMCC_OFS_RATIO, 8'hC1);
      tick_gap(gap);
      check("tick gap pre8", gap, 11'h010);
      do_reset(8'hFF);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_RATIO, 8'h01, 1'b0);
      tick_gap(gap);
      check("tick gap r1", gap, 11'h002);
   endtask
   task automatic s_ee();
      do_reset(8'hFF);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_RATIO, 8'h31, 1'b0);
      ee_adr <= 10'h123;
      ee_er <= 1'b1;
      @(negedge sys_clk);
      check("page0 addr", ee_arr, 11'h123);
      check("split erase", ee_pages, 2'h3);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_CONFIG, 8'h40, 1'b0);
      @(negedge sys_clk);
      check("page1 addr", ee_arr, 11'h523);
      rchk("page rd", NVMCC_OFS_CONFIG, 8'h40);
      check("split erase p1", ee_pages, 2'h3);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_OPTIONS, 8'h20, 1'b0);
      @(negedge sys_clk);
      check("whole erase p1", ee_pages, 2'h2);
      rchk("layout rd", NVMCC_OFS_OPTIONS, 8'h20);
      i_nvmcc_cpu_model.wr_reg(NVMCC_OFS_CONFIG, 8'h00, 1'b0);
      @(negedge sys_clk);
      check("whole erase p0", ee_pages, 2'h1);
   endtask
   // Main sequence
   initial
   begin
      s_decode();
      s_ecc();
      s_bdm();
      s_div();
      s_ee();
      complete_run();
   end
endmodule
